// file: design/sse_pkg.sv
// Package: constants, register map and carrier types of the servo status and encoder output block
package sse_pkg;

    // -----
    // Clock and timing
    // -----
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned ALARM_FREE_DELAY_MS = 1500;
    localparam int unsigned ALARM_FREE_DELAY_CYC = ALARM_FREE_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned ZERO_PULSE_MIN_US = 400;
    localparam int unsigned ZERO_PULSE_MIN_CYC = (ZERO_PULSE_MIN_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned DEF_PULSES_PER_REV = 4000;
    localparam int unsigned DEF_PULSE_DIV = 4;

    // -----
    // Register offsets (byte addresses)
    // -----
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CONFIG = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_REMOTE = 12'h00C;
    localparam logic [11:0] REG_EVENT = 12'h010;
    localparam logic [11:0] REG_MASK = 12'h014;
    localparam logic [11:0] REG_MOTION = 12'h018;

    // -----
    // Control register fields
    // -----
    localparam int CTRL_SERVO_ON = 0;
    localparam int CTRL_RESET = 1;
    localparam int CTRL_ABS_MODE = 2;
    localparam int CTRL_HOME_START = 3;
    localparam int CTRL_HOME_DONE = 4;
    localparam int CTRL_GEAR_CHG = 5;
    localparam int CTRL_ABS_ERASE = 6;
    localparam int CTRL_CNT_WARN = 7;
    localparam int CTRL_ALARM = 8;
    localparam int CTRL_INDEXER = 9;

    // -----
    // Configuration register fields
    // -----
    localparam int CFG_PHASE_SEL = 0;
    localparam int CFG_STATION_DIR = 1;

    // -----
    // Status / remote map / event fields
    // -----
    localparam int ST_READY = 0;
    localparam int ST_ALARM_FREE = 1;
    localparam int ST_HOME_DONE = 2;
    localparam int ST_ESTOP = 3;
    localparam int ST_HOMED_ONCE = 4;
    localparam int ST_HOMING = 5;
    localparam int RM_READY = 0;
    localparam int RM_TROUBLE = 1;
    localparam int RM_HOME_DONE = 2;
    localparam int EV_READY = 0;
    localparam int EV_ALARM = 1;
    localparam int EV_HOME_DONE = 2;
    localparam int EV_ESTOP = 3;
    localparam int EV_WIDTH = 4;

    // -----
    // Reset values
    // -----
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET_VAL = 32'h0000_0000;
    localparam logic [EV_WIDTH-1:0] MASK_RESET_VAL = 4'h0;
    // Edge memory starts at reset levels, so no false event follows reset
    localparam logic [EV_WIDTH-1:0] EV_PREV_RESET_VAL = 4'hA;
    localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;

    // -----
    // Carrier types
    // -----
    typedef struct packed {
        logic pos;
        logic neg;
    } sse_diff_t;

    typedef struct packed {
        sse_diff_t a;
        sse_diff_t b;
        sse_diff_t z;
    } sse_enc_out_t;

    typedef struct packed {
        logic fwd_limit;
        logic rev_limit;
        logic forced_stop;
        logic pulse_fwd;
        logic pulse_rev;
    } sse_pins_t;

    typedef enum logic [2:0] {
        HOME_IDLE = 3'b001,
        HOME_BUSY = 3'b010,
        HOME_DONE = 3'b100
    } sse_home_state_t;

endpackage : sse_pkg

// file: design/sse_status_encoder.sv
// Servo status outputs, remote output map and encoder pulse outputs behind an APB slave
// Operation
// - Ready goes high once the drive is ready after servo-on.
// - Alarm-free drops on base-drive shutoff; low while unpowered. The code drops it on alarm only, not on forced stop.
// - Alarm-free rises within 1.5 s of power-on when no alarm.
// - Remote trouble bit is the inverse of the alarm-free pin.
// - Home-done rises when a home return finishes.
// - Absolute mode: servo-off, forced stop, reset or alarm clear home-done.
// - Absolute mode: either stroke-end input off clears home-done.
// - Absolute mode: new home return needed after erase, warning, gear change, enable.
// - Absolute mode: station direction change or homing in progress clears home-done.
// - With no blocker and homed once, home-done equals ready.
// - A configuration bit picks which phase leads per direction.
// - Exactly one zero pulse per revolution on the Z pair.
// - Zero output is active low at the zero position.
// - Each zero pulse lasts at least about 400 us.
// - Manual pulse inputs are ignored in indexer operation.
// - Each status pin output is mirrored in the remote output map; the encoder pulse outputs are not.
// - Forced stop inactive enters emergency stop; reactivation clears it.
//
// Implementation choices: the APB interface to the registers and the address map.
module sse_status_encoder #(
    parameter int unsigned ALARM_FREE_CYC = sse_pkg::ALARM_FREE_DELAY_CYC,
    parameter int unsigned PULSES_PER_REV = sse_pkg::DEF_PULSES_PER_REV,
    parameter int unsigned PULSE_DIV = sse_pkg::DEF_PULSE_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sse_pkg::sse_pins_t pins_in,
    output logic ready_output,
    output logic alarm_free_output,
    output logic home_done_output,
    output sse_pkg::sse_enc_out_t enc_out,
    output logic irq
);
    import sse_pkg::*;

    // -----
    // Pin synchronisers
    // -----
    sse_pins_t pin_meta_ff;
    sse_pins_t pin_sync_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            pin_meta_ff <= pins_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // -----
    // Register file
    // -----
    logic [31:0] ctrl_ff;
    logic [31:0] config_ff;
    logic [31:0] motion_ff;
    logic [EV_WIDTH-1:0] mask_ff;
    logic [EV_WIDTH-1:0] event_ff;
    logic [EV_WIDTH-1:0] ev_set;
    logic wr_en;
    logic rd_en;
    logic servo_on_command;
    logic reset_command_bit;
    logic abs_mode;
    logic indexer_mode;
    logic alarm_in;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign servo_on_command = ctrl_ff[CTRL_SERVO_ON];
    assign reset_command_bit = ctrl_ff[CTRL_RESET];
    assign abs_mode = ctrl_ff[CTRL_ABS_MODE];
    assign indexer_mode = ctrl_ff[CTRL_INDEXER];
    assign alarm_in = ctrl_ff[CTRL_ALARM];

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == REG_CTRL) || (a == REG_CONFIG) || (a == REG_STATUS)
                  || (a == REG_REMOTE) || (a == REG_EVENT) || (a == REG_MASK)
                  || (a == REG_MOTION);
    endfunction : addr_known

    // Pulse-type control bits self-clear so one write is one event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RESET_VAL;
        end else if (wr_en && paddr == REG_CTRL) begin
            ctrl_ff <= pwdata;
        end else begin
            ctrl_ff[CTRL_HOME_START] <= 1'b0;
            ctrl_ff[CTRL_HOME_DONE] <= 1'b0;
            ctrl_ff[CTRL_GEAR_CHG] <= 1'b0;
            ctrl_ff[CTRL_ABS_ERASE] <= 1'b0;
            ctrl_ff[CTRL_CNT_WARN] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_ff <= CONFIG_RESET_VAL;
            mask_ff <= MASK_RESET_VAL;
            motion_ff <= '0;
        end else if (wr_en) begin
            if (paddr == REG_CONFIG) begin
                config_ff <= pwdata;
            end
            if (paddr == REG_MASK) begin
                mask_ff <= pwdata[EV_WIDTH-1:0];
            end
            if (paddr == REG_MOTION) begin
                motion_ff <= pwdata;
            end
        end
    end

    assign pslverr = psel && penable && !addr_known(paddr);

    // -----
    // Power-on timer and alarm-free output
    // -----
    logic [31:0] pon_cnt_ff;
    logic pon_done;
    logic estop_ff;
    logic base_off;

    assign pon_done = (pon_cnt_ff >= ALARM_FREE_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pon_cnt_ff <= '0;
        end else if (!pon_done) begin
            pon_cnt_ff <= pon_cnt_ff + 32'h0000_0001;
        end
    end

    // Forced stop pin high means active: stop request is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            estop_ff <= 1'b1;
        end else begin
            estop_ff <= !pin_sync_ff.forced_stop;
        end
    end

    assign base_off = alarm_in || estop_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_free_output <= 1'b0;
        end else begin
            alarm_free_output <= pon_done && !alarm_in;
        end
    end

    // -----
    // Ready output
    // -----
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_output <= 1'b0;
        end else begin
            ready_output <= servo_on_command && pon_done && !base_off && !reset_command_bit;
        end
    end

    // -----
    // Home return tracking
    // -----
    sse_home_state_t home_ff;
    sse_home_state_t nxt_home;
    logic homed_once_ff;
    logic abs_mode_d_ff;
    logic station_dir_d_ff;
    logic need_rehome;
    logic blocked;

    // Events that void the absolute origin until a fresh home return
    assign need_rehome = ctrl_ff[CTRL_ABS_ERASE] || ctrl_ff[CTRL_CNT_WARN]
                      || ctrl_ff[CTRL_GEAR_CHG] || (abs_mode && !abs_mode_d_ff)
                      || (config_ff[CFG_STATION_DIR] != station_dir_d_ff);

    always_comb begin
        nxt_home = home_ff;
        case (home_ff)
            HOME_IDLE: begin
                if (ctrl_ff[CTRL_HOME_START]) begin
                    nxt_home = HOME_BUSY;
                end
            end
            HOME_BUSY: begin
                if (ctrl_ff[CTRL_HOME_DONE]) begin
                    nxt_home = HOME_DONE;
                end
            end
            HOME_DONE: begin
                if (ctrl_ff[CTRL_HOME_START]) begin
                    nxt_home = HOME_BUSY;
                end else if (abs_mode && need_rehome) begin
                    nxt_home = HOME_IDLE;
                end
            end
            default: begin
                nxt_home = HOME_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_ff <= HOME_IDLE;
            abs_mode_d_ff <= 1'b0;
            station_dir_d_ff <= 1'b0;
        end else begin
            home_ff <= nxt_home;
            abs_mode_d_ff <= abs_mode;
            station_dir_d_ff <= config_ff[CFG_STATION_DIR];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            homed_once_ff <= 1'b0;
        end else if (nxt_home == HOME_DONE) begin
            homed_once_ff <= 1'b1;
        end else if (nxt_home == HOME_IDLE && home_ff == HOME_DONE) begin
            homed_once_ff <= 1'b0;
        end
    end

    assign blocked = !servo_on_command || estop_ff || reset_command_bit || alarm_in
                  || !pin_sync_ff.fwd_limit || !pin_sync_ff.rev_limit
                  || (home_ff == HOME_BUSY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_done_output <= 1'b0;
        end else if (abs_mode) begin
            home_done_output <= !blocked && homed_once_ff && !need_rehome
                             && servo_on_command && pon_done && !base_off;
        end else begin
            home_done_output <= (home_ff == HOME_DONE);
        end
    end

    // -----
    // Encoder pulse output
    // -----
    // Motion register: bit 0 run, bit 1 direction; manual pulse pins step when not indexing
    logic [15:0] div_ff;
    logic step_en;
    logic step_dir;
    logic [1:0] quad_ff;
    logic [31:0] pos_ff;
    logic [15:0] zw_ff;
    logic man_fwd_d_ff;
    logic man_rev_d_ff;
    logic man_fwd;
    logic man_rev;

    assign man_fwd = pin_sync_ff.pulse_fwd && !man_fwd_d_ff && !indexer_mode;
    assign man_rev = pin_sync_ff.pulse_rev && !man_rev_d_ff && !indexer_mode;
    assign step_en = (motion_ff[0] && div_ff == 16'(PULSE_DIV - 1)) || man_fwd || man_rev;
    assign step_dir = (motion_ff[0] && div_ff == 16'(PULSE_DIV - 1)) ? motion_ff[1] : man_rev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
            man_fwd_d_ff <= 1'b0;
            man_rev_d_ff <= 1'b0;
        end else begin
            div_ff <= (div_ff == 16'(PULSE_DIV - 1)) ? 16'h0000 : div_ff + 16'h0001;
            man_fwd_d_ff <= pin_sync_ff.pulse_fwd;
            man_rev_d_ff <= pin_sync_ff.pulse_rev;
        end
    end

    // Two-bit binary count, Gray-decoded onto A and B, gives the quarter-cycle offset; selector reverses the count sense
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_ff <= 2'h0;
            pos_ff <= '0;
        end else if (step_en) begin
            if (step_dir ^ config_ff[CFG_PHASE_SEL]) begin
                quad_ff <= quad_ff - 2'h1;
            end else begin
                quad_ff <= quad_ff + 2'h1;
            end
            if (step_dir) begin
                pos_ff <= (pos_ff == 32'h0000_0000) ? 32'(PULSES_PER_REV - 1) : pos_ff - 32'h1;
            end else begin
                pos_ff <= (pos_ff == 32'(PULSES_PER_REV - 1)) ? 32'h0000_0000 : pos_ff + 32'h1;
            end
        end
    end

    // Zero pulse stretched so slow hosts still catch it at high speed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zw_ff <= '0;
        end else if (step_en && pos_ff == 32'h0000_0000) begin
            zw_ff <= 16'(ZERO_PULSE_MIN_CYC);
        end else if (zw_ff != 16'h0000) begin
            zw_ff <= zw_ff - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_out <= 6'h16;
        end else begin
            enc_out.a.pos <= quad_ff[1] ^ quad_ff[0];
            enc_out.a.neg <= !(quad_ff[1] ^ quad_ff[0]);
            enc_out.b.pos <= quad_ff[1];
            enc_out.b.neg <= !quad_ff[1];
            enc_out.z.pos <= (zw_ff == 16'h0000);
            enc_out.z.neg <= (zw_ff != 16'h0000);
        end
    end

    // -----
    // Events, interrupt and read path
    // -----
    logic [EV_WIDTH-1:0] prev_ff;
    logic [EV_WIDTH-1:0] cur;

    assign cur = {estop_ff, home_done_output, !alarm_free_output, ready_output};
    assign ev_set = cur & ~prev_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= EV_PREV_RESET_VAL;
            event_ff <= '0;
        end else begin
            prev_ff <= cur;
            if (rd_en && paddr == REG_EVENT) begin
                event_ff <= ev_set; // set wins over read clear
            end else begin
                event_ff <= event_ff | ev_set;
            end
        end
    end

    assign irq = |(event_ff & mask_ff);

    always_comb begin
        prdata = BUS_ERR_DATA;
        if (rd_en) begin
            case (paddr)
                REG_CTRL: prdata = ctrl_ff;
                REG_CONFIG: prdata = config_ff;
                REG_STATUS: prdata = {26'h0, home_ff == HOME_BUSY, homed_once_ff, estop_ff,
                                      home_done_output, alarm_free_output, ready_output};
                REG_REMOTE: prdata = {29'h0, home_done_output, !alarm_free_output,
                                      ready_output};
                REG_EVENT: prdata = {28'h0, event_ff};
                REG_MASK: prdata = {28'h0, mask_ff};
                REG_MOTION: prdata = motion_ff;
                default: prdata = BUS_ERR_DATA;
            endcase
        end
    end

endmodule : sse_status_encoder

// file: tb/sse_props.sv
// Checker: port-level properties of the servo status and encoder block
module sse_props
    import sse_pkg::*;
#(
    parameter int unsigned ALARM_FREE_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire sse_pkg::sse_pins_t pins_in,
    input wire logic ready_output,
    input wire logic alarm_free_output,
    input wire logic home_done_output,
    input wire sse_pkg::sse_enc_out_t enc_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] ctrl_ff;
    logic run_ff;
    int unsigned up_ff;
    int unsigned zlow_ff;
    wire logic acc = psel && penable && pwrite;
    // -----
    // Shadow of control words, seen on the bus
    // -----
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RESET_VAL;
            run_ff <= 1'b0;
        end else if (acc && paddr == REG_CTRL) begin
            ctrl_ff <= pwdata;
        end else if (acc && paddr == REG_MOTION) begin
            run_ff <= pwdata[0];
        end
    end
    // Saturating so a long run cannot wrap back into the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_ff <= 0;
            zlow_ff <= 0;
        end else begin
            up_ff <= (up_ff < ALARM_FREE_CYC + 9) ? up_ff + 1 : up_ff;
            zlow_ff <= enc_out.z.pos ? 0 : zlow_ff + 1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_stop_held;
        !pins_in.forced_stop [*5];
    endsequence
    sequence s_limit_off;
        (ctrl_ff[CTRL_ABS_MODE] && !(pins_in.fwd_limit && pins_in.rev_limit)) [*5];
    endsequence
    a_ready_servo_off: assert property (
        (!ctrl_ff[CTRL_SERVO_ON] || ctrl_ff[CTRL_RESET]) [*2] |-> !ready_output)
        else $error("ready high without servo-on");
    a_alarm_drops: assert property ($rose(ctrl_ff[CTRL_ALARM]) |-> ##[0:2] !alarm_free_output)
        else $error("alarm-free stayed high on alarm");
    a_alarm_free_rise: assert property (
        up_ff == ALARM_FREE_CYC && !$past(ctrl_ff[CTRL_ALARM]) |-> alarm_free_output)
        else $error("alarm-free late after reset");
    a_remote_mirror: assert property (psel && penable && !pwrite && paddr == REG_REMOTE
        |-> prdata[RM_TROUBLE] == !alarm_free_output && prdata[RM_READY] == ready_output
        && prdata[RM_HOME_DONE] == home_done_output)
        else $error("remote map differs from pins");
    a_estop_ready: assert property (s_stop_held |-> !ready_output)
        else $error("ready high in emergency stop");
    a_limit_home: assert property (s_limit_off |-> !home_done_output)
        else $error("home-done high with stroke end off");
    a_home_ready: assert property (
        ctrl_ff[CTRL_ABS_MODE] && home_done_output |-> ready_output || $past(ready_output))
        else $error("home-done without ready");
    a_enc_diff: assert property (enc_out.a.neg == !enc_out.a.pos
        && enc_out.b.neg == !enc_out.b.pos && enc_out.z.neg == !enc_out.z.pos)
        else $error("encoder pair not complementary");
    a_quad_step: assert property (!($changed(enc_out.a.pos) && $changed(enc_out.b.pos)))
        else $error("both phases moved at once");
    a_zero_width: assert property ($rose(enc_out.z.pos) |-> zlow_ff >= ZERO_PULSE_MIN_CYC)
        else $error("zero pulse too short");
    a_manual_ignored: assert property (
        (ctrl_ff[CTRL_INDEXER] && !run_ff) [*3] |-> $stable(enc_out.a) && $stable(enc_out.b))
        else $error("encoder moved in indexer mode");
endmodule : sse_props

bind sse_status_encoder sse_props #(.ALARM_FREE_CYC(ALARM_FREE_CYC)) props_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pins_in(pins_in),
    .ready_output(ready_output), .alarm_free_output(alarm_free_output),
    .home_done_output(home_done_output), .enc_out(enc_out));

// file: tb/sse_host_model.sv
// Host controller model: drives the pins, decodes the encoder pulse outputs
module sse_host_model
    import sse_pkg::*;
(
    input wire logic pclk,
    input wire sse_pkg::sse_pins_t pins_cmd,
    input wire sse_pkg::sse_enc_out_t enc_out,
    output sse_pkg::sse_pins_t pins_in,
    output logic a_leads,
    output int unsigned rev_steps
);
    timeunit 1ns;
    timeprecision 1ns;
    logic a_q = 1'b0, b_q = 1'b0;
    logic z_q = 1'b1;
    logic moved;
    int unsigned steps = 0;
    initial pins_in = '0;
    initial a_leads = 1'b0;
    initial rev_steps = 0;
    assign moved = (enc_out.a.pos != a_q) || (enc_out.b.pos != b_q);
    // Steps are counted between zero-pulse fronts, so the boundary step lands once
    always @(posedge pclk) begin
        pins_in <= pins_cmd;
        a_q <= enc_out.a.pos;
        b_q <= enc_out.b.pos;
        z_q <= enc_out.z.pos;
        if (enc_out.a.pos != a_q)
            a_leads <= (enc_out.a.pos != enc_out.b.pos);
        if (z_q && !enc_out.z.pos) begin
            rev_steps <= steps;
            steps <= moved ? 1 : 0;
        end else if (moved) begin
            steps <= steps + 1;
        end
    end
endmodule : sse_host_model

// file: tb/tb.sv
// Testbench: drives APB and pins, checks status and encoder outputs
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sse_pkg::*;

    localparam int unsigned AF_CYC = 20;
    localparam logic [31:0] SA = 32'h0000_0005;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sse_pins_t pins_cmd;
    sse_pins_t pins_in;
    logic ready_output, alarm_free_output, home_done_output;
    sse_enc_out_t enc_out;
    logic irq;
    logic a_leads;
    int unsigned rev_steps;
    logic [31:0] rdata, r, c;
    logic rerr;
    logic lead0;
    logic [5:0] e0;
    logic [31:0] seed = 32'h0000_8484;
    int n_errors = 0;
    int comparisons = 0;

    // Slow stepping keeps each zero pulse well inside one revolution
    sse_status_encoder #(.ALARM_FREE_CYC(AF_CYC), .PULSES_PER_REV(8), .PULSE_DIV(1000)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_in(pins_in), .ready_output(ready_output), .alarm_free_output(alarm_free_output),
        .home_done_output(home_done_output), .enc_out(enc_out), .irq(irq));
    sse_host_model host_u (.pclk(pclk), .pins_cmd(pins_cmd), .enc_out(enc_out),
        .pins_in(pins_in), .a_leads(a_leads), .rev_steps(rev_steps));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic exp_ready(input logic [31:0] w, input logic run_ok);
        return w[CTRL_SERVO_ON] & ~w[CTRL_ALARM] & ~w[CTRL_RESET] & run_ok;
    endfunction : exp_ready
    task automatic results();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Entered just after a rising edge; returns just after one
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        wait_n(60000);
        n_errors++;
        results();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pins_cmd = 5'b11100;
        wait_n(5);
        chk("enc in reset", 32'h16, enc_out);
        wait_n(5);
        presetn <= 1'b1;
        wait_n(1);
        chk("alarm-free at start", 0, alarm_free_output);
        apb(0, REG_CTRL, 0);
        chk("ctrl reset", CTRL_RESET_VAL, rdata);
        apb(0, REG_CONFIG, 0);
        chk("config reset", CONFIG_RESET_VAL, rdata);
        apb(0, 12'h100, 0);
        chk("unmapped err", 1, rerr);
        chk("unmapped data", 0, rdata);
        wait_n(AF_CYC);
        chk("alarm-free up", 1, alarm_free_output);
        // -----
        // Random control words and forced stop
        // -----
        for (int i = 0; i < 16; i++) begin
            r = xs();
            c = (r & 32'h0000_0103) | {31'h0, r[9]};
            pins_cmd.forced_stop <= r[4] | r[5];
            apb(1, REG_CTRL, c);
            wait_n(6);
            chk("ready", exp_ready(c, r[4] | r[5]), ready_output);
            chk("alarm-free", !c[CTRL_ALARM], alarm_free_output);
            apb(0, REG_REMOTE, 0);
            chk("remote", {30'h0, c[CTRL_ALARM], exp_ready(c, r[4] | r[5])}, rdata);
        end
        pins_cmd <= 5'b11100;
        // -----
        // Absolute mode home-done blockers
        // -----
        apb(1, REG_CTRL, SA);
        wait_n(6);
        chk("home before homing", 0, home_done_output);
        for (int i = 0; i < 10; i++) begin
            apb(1, REG_CTRL, SA | 32'h8);
            wait_n(3);
            chk("home while homing", 0, home_done_output);
            apb(1, REG_CTRL, SA | 32'h10);
            wait_n(4);
            chk("home done", 1, home_done_output);
            chk("ready with home", 1, ready_output);
            case (i)
                0: apb(1, REG_CTRL, 32'h4);
                1: apb(1, REG_CTRL, SA | 32'h2);
                2: apb(1, REG_CTRL, SA | 32'h100);
                3: apb(1, REG_CTRL, SA | 32'h20);
                4: apb(1, REG_CTRL, SA | 32'h40);
                5: apb(1, REG_CTRL, SA | 32'h80);
                6: pins_cmd.forced_stop <= 1'b0;
                7: pins_cmd.fwd_limit <= 1'b0;
                8: pins_cmd.rev_limit <= 1'b0;
                default: apb(1, REG_CONFIG, 32'h2);
            endcase
            wait_n(6);
            chk("home blocked", 0, home_done_output);
            pins_cmd <= 5'b11100;
            apb(1, REG_CTRL, SA);
            wait_n(6);
        end
        // -----
        // Interrupt: masked event, read clear
        // -----
        apb(1, REG_CTRL, 32'h1);
        wait_n(4);
        apb(0, REG_EVENT, 0);
        apb(1, REG_MASK, 32'h2);
        chk("irq idle", 0, irq);
        apb(1, REG_CTRL, 32'h101);
        wait_n(4);
        chk("irq raised", 1, irq);
        apb(0, REG_EVENT, 0);
        chk("event", 32'h2, rdata);
        chk("irq cleared", 0, irq);
        apb(1, REG_MASK, 0);
        apb(1, REG_CTRL, 32'h1);
        // -----
        // Encoder phase order and revolution
        // -----
        for (int i = 0; i < 4; i++) begin
            apb(1, REG_CONFIG, 32'h2 | i[0]);
            apb(1, REG_MOTION, {30'h0, i[1], 1'b1});
            wait_n(4500);
            if (i == 0)
                lead0 = a_leads;
            chk("phase lead", lead0 ^ i[0] ^ i[1], a_leads);
        end
        apb(1, REG_CONFIG, 32'h2);
        apb(1, REG_MOTION, 32'h1);
        wait_n(20000);
        chk("steps per rev", 8, rev_steps);
        apb(1, REG_MOTION, 0);
        for (int j = 0; j < 2; j++) begin
            apb(1, REG_CTRL, j ? 32'h1 : 32'h201);
            wait_n(4);
            e0 = enc_out;
            for (int i = 0; i < 3; i++) begin
                pins_cmd.pulse_fwd <= 1'b1;
                wait_n(4);
                pins_cmd.pulse_fwd <= 1'b0;
                wait_n(4);
            end
            chk("manual moves", j, enc_out[5:2] != e0[5:2]);
        end
        results();
    end
endmodule : tb
